// file: design/iotl_defs.svh
// Purpose: Offsets, field positions and reset values of the I/O translator
// Assumes: Included by the translator module only
// Notes:   Bit positions use big-endian numbering (bit 31 = PA bit 0)
`ifndef IOTL_DEFS_SVH
`define IOTL_DEFS_SVH

// Register offsets (byte addresses, one aligned word each)
`define IOTL_OFS_ENTRY_UPPER   8'h00
`define IOTL_OFS_ENTRY_LOWER   8'h04
`define IOTL_OFS_INDEX_MASK    8'h08
`define IOTL_OFS_CONTROL       8'h0c
`define IOTL_OFS_WRITE_INDEX   8'h10
`define IOTL_OFS_DIR_BASE      8'h14
`define IOTL_OFS_STATUS        8'h18

// Control register bits
`define IOTL_CTL_INSTALL       0
`define IOTL_CTL_AUTO_FETCH    1

// Upper word fields (PA bits 6..15 and 24..31)
`define IOTL_UP_VIDX_HI        25
`define IOTL_UP_VIDX_LO        16
`define IOTL_UP_PPN_HI         7
`define IOTL_UP_PPN_LO         0

// Lower word fields (PA bits 0..19, 25, 29..30, 31)
`define IOTL_LO_PPN_HI         31
`define IOTL_LO_PPN_LO         12
`define IOTL_LO_PREFETCH       6
`define IOTL_LO_TYPE_HI        2
`define IOTL_LO_TYPE_LO        1
`define IOTL_LO_VALID          0

// I/O address layout
`define IOTL_OFFSET_BITS       12
`define IOTL_TAG_HI            23
`define IOTL_TAG_LO            12

// Reset values
`define IOTL_RST_MASK          32'hff00_0000
`define IOTL_RST_WORD          32'h0000_0000
`define IOTL_RST_CONTROL       32'h0000_0002

`endif

// file: design/iotl_pkg.sv
// Purpose: Types shared by the I/O translator
// Assumes: Nothing beyond the constants header
// Notes:   Holds only the page type and state enumerations
package iotl_pkg;
    // Coherent page type, bit0 = safe, bit1 = lock, bit1..0 per encoding
    typedef enum logic [1:0] {
        IOTL_FAST_NOLOCK = 2'h0,
        IOTL_SAFE_NOLOCK = 2'h1,
        IOTL_FAST_LOCK   = 2'h2,
        IOTL_SAFE_LOCK   = 2'h3
    } iotl_page_type;
    // Translator sequencing
    typedef enum logic [2:0] {
        IOTL_IDLE,
        IOTL_LOOKUP,
        IOTL_FETCH,
        IOTL_WAIT_DATA,
        IOTL_ISSUE,
        IOTL_STALL
    } iotl_state_type;
endpackage : iotl_pkg

// file: design/iotl_translator.sv
// Purpose: Inbound I/O address translation with a 256-entry table
// Assumes: One clock, synchronous active-high reset, same-domain partners
// Notes:   Register port answers reads one cycle later, never stalls
//          Index mask legality is left to software, nothing checks it
//          Directory words carry no tag; the missing address supplies it
// Functional notes
// - Entry is one 64-bit upper/lower pair
// - Entries load from registers or directory
// - Upper word: virtual index, real address top
// - Lower word: page number, prefetch, type, valid
// - Prefetch bit zero forbids prefetching
// - Page type selects fast/safe and lock
// - Valid bit one marks entry valid
// - Translate only at head of queue
// - Offset bits eleven to four pass unchanged
// - Eight-bit index extracted by mask
// - Tag always address bits twelve to twenty-three
// - Mask position picks index field
// - Hit needs tag match and valid
// - Physical address is page plus offset
// - Drop low four address bits
// - Present virtual index with request
// - Page type chooses transaction and lock
// - Prefetch only for capable requesters
// - Miss fetches entry from directory
`include "iotl_defs.svh"

module iotl_translator
    import iotl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Head of inbound queue
    input  wire logic        inq_valid,
    input  wire logic [31:0] inq_addr,
    input  wire logic        inq_prefetch_capable,
    output logic             inq_pop,
    // Directory fetch request and return
    output logic             dir_req,
    output logic      [35:0] dir_addr,
    input  wire logic        dir_ack,
    input  wire logic        dir_data_valid,
    input  wire logic [63:0] dir_data,
    // System bus request
    output logic             sys_req,
    output logic      [35:0] sys_addr,
    output logic      [9:0]  sys_vindex,
    output logic      [1:0]  sys_page_type,
    output logic             sys_lock_allowed,
    output logic             sys_safe_dma,
    output logic             sys_prefetch_ok,
    input  wire logic        sys_ack,
    // Level that shows a miss stall
    output logic             miss_stall
);

    // Table storage: upper word, lower word, tag per entry
    logic [31:0] ent_up_reg  [256];             // Upper halves
    logic [31:0] ent_lo_reg  [256];             // Lower halves
    logic [11:0] ent_tag_reg [256];             // Stored tags

    // Software registers
    logic [31:0] upper_reg;                     // Entry upper word
    logic [31:0] lower_reg;                     // Entry lower word
    logic [31:0] mask_reg;                      // Table index mask
    logic [31:0] control_reg;                   // Control bits
    logic [31:0] windex_reg;                    // Write index and tag
    logic [31:0] dir_base_reg;                  // Directory base
    logic [31:0] miss_count_reg;                // Misses counted

    iotl_state_type state_reg;                  // Sequencer state
    logic [31:0]    addr_reg;                   // Latched head address
    logic           pf_cap_reg;                 // Latched capability
    logic [7:0]     idx_reg;                    // Latched index

    // Combinational lookup
    logic [7:0]  idx_next;                      // Extracted index
    logic [11:0] tag_cur;                       // Tag of latched address
    logic [31:0] up_cur;                        // Read upper word
    logic [31:0] lo_cur;                        // Read lower word
    logic        hit;                           // Lookup hit
    logic        sw_install;                    // Software install pulse
    logic        dir_install;                   // Directory install pulse

    always_comb begin
        idx_next = 8'h00;
        // Legal masks keep offset bits clear, so none leak in
        for (int g = 0; g < 3; g++) begin
            // Three eight-bit AND arrays, ORed together
            idx_next = idx_next
                | (inq_addr[31-8*g -: 8] & mask_reg[31-8*g -: 8]);
        end
        // One four-bit array folds the leftover low bits 7..4
        idx_next = idx_next
            | {(inq_addr[7:4] & mask_reg[7:4]), 4'h0};
    end

    assign tag_cur = addr_reg[`IOTL_TAG_HI:`IOTL_TAG_LO];
    assign up_cur  = ent_up_reg[idx_reg];
    assign lo_cur  = ent_lo_reg[idx_reg];

    assign hit = lo_cur[`IOTL_LO_VALID]
               && (ent_tag_reg[idx_reg] == tag_cur);

    assign sw_install = reg_write
                     && (reg_addr == `IOTL_OFS_CONTROL)
                     && reg_wdata[`IOTL_CTL_INSTALL];
    assign dir_install = (state_reg == IOTL_WAIT_DATA) && dir_data_valid;

    // Register writes
    always_ff @(posedge clk) begin
        if (reset) begin
            upper_reg    <= `IOTL_RST_WORD;
            lower_reg    <= `IOTL_RST_WORD;
            mask_reg     <= `IOTL_RST_MASK;
            control_reg  <= `IOTL_RST_CONTROL;
            windex_reg   <= `IOTL_RST_WORD;
            dir_base_reg <= `IOTL_RST_WORD;
        end else if (reg_write) begin
            if (reg_addr == `IOTL_OFS_ENTRY_UPPER) begin
                upper_reg <= reg_wdata;
            end else if (reg_addr == `IOTL_OFS_ENTRY_LOWER) begin
                lower_reg <= reg_wdata;
            end else if (reg_addr == `IOTL_OFS_INDEX_MASK) begin
                mask_reg <= reg_wdata;
            end else if (reg_addr == `IOTL_OFS_CONTROL) begin
                // Install bit is self-clearing
                control_reg <= {reg_wdata[31:1], 1'b0};
            end else if (reg_addr == `IOTL_OFS_WRITE_INDEX) begin
                windex_reg <= reg_wdata;
            end else if (reg_addr == `IOTL_OFS_DIR_BASE) begin
                dir_base_reg <= reg_wdata;
            end
        end
    end

    // Register reads, data one cycle after strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            if (reg_addr == `IOTL_OFS_ENTRY_UPPER) begin
                reg_rdata <= upper_reg;
            end else if (reg_addr == `IOTL_OFS_ENTRY_LOWER) begin
                reg_rdata <= lower_reg;
            end else if (reg_addr == `IOTL_OFS_INDEX_MASK) begin
                reg_rdata <= mask_reg;
            end else if (reg_addr == `IOTL_OFS_CONTROL) begin
                reg_rdata <= control_reg;
            end else if (reg_addr == `IOTL_OFS_WRITE_INDEX) begin
                reg_rdata <= windex_reg;
            end else if (reg_addr == `IOTL_OFS_DIR_BASE) begin
                reg_rdata <= dir_base_reg;
            end else if (reg_addr == `IOTL_OFS_STATUS) begin
                reg_rdata <= miss_count_reg;
            end else begin
                // Unmapped reads as zero
                reg_rdata <= 32'h0000_0000;
            end
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            // Reset first, so a stray install strobe cannot survive it
            // Only the valid bits clear; the rest may stay unknown
            for (int e = 0; e < 256; e++) begin
                ent_lo_reg[e][`IOTL_LO_VALID] <= 1'b0;
            end
        end else if (dir_install) begin
            // Directory wins over a same-cycle software install
            ent_up_reg[idx_reg]  <= dir_data[63:32];
            ent_lo_reg[idx_reg]  <= dir_data[31:0];
            ent_tag_reg[idx_reg] <= tag_cur;
        end else if (sw_install) begin
            // Software install at the written index and tag
            ent_up_reg[windex_reg[7:0]]  <= upper_reg;
            ent_lo_reg[windex_reg[7:0]]  <= lower_reg;
            ent_tag_reg[windex_reg[7:0]] <= windex_reg[19:8];
        end
    end

    // Miss counter for software
    always_ff @(posedge clk) begin
        if (reset) begin
            miss_count_reg <= 32'h0000_0000;
        end else if (state_reg == IOTL_LOOKUP && !hit) begin
            miss_count_reg <= miss_count_reg + 32'h0000_0001;
        end
    end

    // Sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg  <= IOTL_IDLE;
            addr_reg   <= 32'h0000_0000;
            pf_cap_reg <= 1'b0;
            idx_reg    <= 8'h00;
        end else begin
            case (state_reg)
                IOTL_IDLE: begin
                    // Pop still high: the old head is leaving
                    // Start only at queue head
                    if (inq_valid && !inq_pop) begin
                        addr_reg   <= inq_addr;
                        pf_cap_reg <= inq_prefetch_capable;
                        idx_reg    <= idx_next;
                        state_reg  <= IOTL_LOOKUP;
                    end
                end
                IOTL_LOOKUP: begin
                    if (hit) begin
                        // Hit: request goes out next cycle
                        state_reg <= IOTL_ISSUE;
                    end else if (control_reg[`IOTL_CTL_AUTO_FETCH]) begin
                        // Miss: fetch from the directory
                        state_reg <= IOTL_FETCH;
                    end else begin
                        // Miss, no auto fetch: wait for software
                        state_reg <= IOTL_STALL;
                    end
                end
                IOTL_FETCH: begin
                    // Request stands until the directory takes it
                    if (dir_ack) begin
                        state_reg <= IOTL_WAIT_DATA;
                    end
                end
                IOTL_WAIT_DATA: begin
                    if (dir_data_valid) begin
                        state_reg <= IOTL_LOOKUP;
                    end
                end
                IOTL_STALL: begin
                    if (sw_install) begin
                        state_reg <= IOTL_LOOKUP;
                    end
                end
                IOTL_ISSUE: begin
                    // Attributes stay loaded until the bus takes them
                    if (sys_ack) begin
                        state_reg <= IOTL_IDLE;
                    end
                end
                default: begin
                    state_reg <= IOTL_IDLE;
                end
            endcase
        end
    end

    // Queue pop pulse the cycle after the system bus takes the request
    always_ff @(posedge clk) begin
        if (reset) begin
            inq_pop <= 1'b0;
        end else begin
            inq_pop <= (state_reg == IOTL_ISSUE) && sys_ack;
        end
    end

    // Directory request address: base plus page number, quad words
    // One directory word of eight bytes per page of I/O space
    always_ff @(posedge clk) begin
        if (reset) begin
            dir_req  <= 1'b0;
            dir_addr <= 36'h0_0000_0000;
        end else begin
            dir_req  <= (state_reg == IOTL_FETCH) && !dir_ack;
            dir_addr <= {4'h0, dir_base_reg}
                      + {13'h0000, addr_reg[31:`IOTL_OFFSET_BITS], 3'h0};
        end
    end

    // System bus request and attributes, loaded on a hit
    always_ff @(posedge clk) begin
        if (reset) begin
            sys_req          <= 1'b0;
            sys_addr         <= 36'h0_0000_0000;
            sys_vindex       <= 10'h000;
            sys_page_type    <= 2'h0;
            sys_lock_allowed <= 1'b0;
            sys_safe_dma     <= 1'b0;
            sys_prefetch_ok  <= 1'b0;
        end else if (state_reg == IOTL_LOOKUP && hit) begin
            sys_req  <= 1'b1;
            // Drop byte bits three to zero
            sys_addr <= {up_cur[`IOTL_UP_PPN_HI:`IOTL_UP_PPN_LO],
                         lo_cur[`IOTL_LO_PPN_HI:`IOTL_LO_PPN_LO],
                         addr_reg[`IOTL_OFFSET_BITS-1:4]};
            sys_vindex <= up_cur[`IOTL_UP_VIDX_HI:`IOTL_UP_VIDX_LO];
            sys_page_type <= lo_cur[`IOTL_LO_TYPE_HI:`IOTL_LO_TYPE_LO];
            sys_lock_allowed <= lo_cur[`IOTL_LO_TYPE_HI];
            sys_safe_dma     <= lo_cur[`IOTL_LO_TYPE_LO];
            sys_prefetch_ok <= lo_cur[`IOTL_LO_PREFETCH] && pf_cap_reg;
        end else if (state_reg == IOTL_ISSUE && sys_ack) begin
            sys_req <= 1'b0;
        end
    end

    // Stall indicator
    // Covers the directory wait as well as the software wait
    always_ff @(posedge clk) begin
        if (reset) begin
            miss_stall <= 1'b0;
        end else begin
            miss_stall <= (state_reg == IOTL_STALL)
                       || (state_reg == IOTL_FETCH)
                       || (state_reg == IOTL_WAIT_DATA);
        end
    end

endmodule : iotl_translator

// file: dv/iotl_checker.sv
// Purpose: Temporal checks at the translator ports
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the translator from the bench top file
module iotl_checker (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        inq_valid,
    input wire logic [31:0] inq_addr,
    input wire logic        inq_prefetch_capable,
    input wire logic        inq_pop,
    input wire logic        sys_req,
    input wire logic [35:0] sys_addr,
    input wire logic [1:0]  sys_page_type,
    input wire logic        sys_lock_allowed,
    input wire logic        sys_safe_dma,
    input wire logic        sys_prefetch_ok,
    input wire logic        sys_ack,
    input wire logic        miss_stall
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // New head after an empty cycle
    sequence s_new_head;
        !inq_valid ##1 inq_valid;
    endsequence
    // Latch and lookup cycles stay quiet
    sequence s_lookup;
        !sys_req ##1 !sys_req;
    endsequence
    // Request taken by the system bus
    sequence s_taken;
        sys_req && sys_ack;
    endsequence
    AST_LOOKUP_GAP: assert property (
        s_new_head |-> s_lookup)
        else $error("request before lookup done");
    AST_REQ_AT_HEAD: assert property (
        sys_req |-> inq_valid)
        else $error("request without queue head");
    AST_OFFSET_PASS: assert property (
        sys_req |-> sys_addr[7:0] == inq_addr[11:4])
        else $error("page offset altered");
    AST_TYPE_SPLIT: assert property (
        sys_req |-> {sys_lock_allowed, sys_safe_dma} == sys_page_type)
        else $error("lock or safe flag wrong");
    AST_PREFETCH_GATE: assert property (
        sys_req && !inq_prefetch_capable |-> !sys_prefetch_ok)
        else $error("prefetch for incapable requester");
    AST_REQ_HOLD: assert property (
        sys_req && !sys_ack |=> sys_req && $stable(sys_addr)
            && $stable(sys_page_type) && $stable(sys_prefetch_ok))
        else $error("request changed before acknowledge");
    AST_POP_AFTER_ACK: assert property (
        s_taken |=> inq_pop && !sys_req ##1 !inq_pop)
        else $error("pop not one cycle after acknowledge");
    AST_STALL_BLOCKS: assert property (
        miss_stall |-> !sys_req)
        else $error("request issued during miss");
endmodule : iotl_checker

// file: dv/iotl_far_model.sv
// Purpose: Memory directory and system bus seen by the translator
// Assumes: Same clock as the translator
// Notes:   One latency serves both answers; zero answers in the next cycle
module iotl_far_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [3:0]  lat,
    input  wire logic [63:0] dir_word,
    input  wire logic        dir_req,
    output logic             dir_ack,
    output logic             dir_data_valid,
    output logic      [63:0] dir_data,
    input  wire logic        sys_req,
    output logic             sys_ack
);
    logic [3:0] sys_cnt_reg;  // Cycles the bus has kept us waiting
    logic [3:0] dir_cnt_reg;  // Cycles spent in a directory phase
    logic       dir_busy_reg; // Read taken, word still to return
    // Released data lines show garbage, not the last word
    assign dir_data = dir_data_valid ? dir_word : ~dir_word;
    // Bus takes a request after the chosen wait
    always_ff @(posedge clk) begin
        sys_ack <= 1'b0;
        if (reset) begin
            sys_cnt_reg <= 4'h0;
        end else if (sys_req && !sys_ack) begin
            sys_ack     <= (sys_cnt_reg == lat);
            sys_cnt_reg <= (sys_cnt_reg == lat) ? 4'h0 : sys_cnt_reg + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        dir_ack        <= 1'b0;
        dir_data_valid <= 1'b0;
        if (reset) begin
            dir_cnt_reg  <= 4'h0;
            dir_busy_reg <= 1'b0;
        end else if (dir_busy_reg || (dir_req && !dir_ack)) begin
            dir_cnt_reg <= (dir_cnt_reg == lat) ? 4'h0 : dir_cnt_reg + 4'h1;
            if (dir_cnt_reg == lat) begin
                dir_ack        <= !dir_busy_reg;
                dir_data_valid <= dir_busy_reg;
                dir_busy_reg   <= !dir_busy_reg;
            end
        end
    end
endmodule : iotl_far_model

// file: dv/iotl_translator_bench.sv
// Purpose: Self-checking bench of the I/O translator
// Assumes: Far model answers directory reads and system requests
// Notes:   Entries are built field by field
module iotl_translator_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, reset = 1'b1, reg_write = 1'b0;
    logic        reg_read = 1'b0, inq_valid = 1'b0, inq_prefetch_capable;
    logic        inq_pop, dir_req, dir_ack, dir_data_valid, sys_req;
    logic        sys_ack, sys_lock_allowed, sys_safe_dma, sys_prefetch_ok;
    logic        miss_stall, saw_stall;
    logic [1:0]  sys_page_type;
    logic [3:0]  lat = 4'h0;
    logic [7:0]  reg_addr = 8'h00;
    logic [9:0]  sys_vindex;
    logic [31:0] reg_wdata = 32'h0, inq_addr = 32'h0, reg_rdata;
    logic [35:0] dir_addr, sys_addr;
    logic [63:0] dir_data, dir_word = 64'h0;
    int          n_fail = 0, cmp_count = 0;
    initial inq_prefetch_capable = 1'b0;
    // 50 MHz clock
    initial forever #10 clk = ~clk;
    iotl_translator u_iotl_translator (.clk, .reset, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .inq_valid, .inq_addr,
        .inq_prefetch_capable, .inq_pop, .dir_req, .dir_addr, .dir_ack,
        .dir_data_valid, .dir_data, .sys_req, .sys_addr, .sys_vindex,
        .sys_page_type, .sys_lock_allowed, .sys_safe_dma, .sys_prefetch_ok,
        .sys_ack, .miss_stall);
    iotl_far_model u_iotl_far_model (.clk, .reset, .lat, .dir_word,
        .dir_req, .dir_ack, .dir_data_valid, .dir_data, .sys_req, .sys_ack);
    // Compare and count
    task automatic chk(string n, logic [35:0] e, logic [35:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // One write strobe cycle
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    // Read strobe, data judged in the next cycle
    task automatic rdc(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk("reg_rdata", {4'h0, e}, {4'h0, reg_rdata});
    endtask : rdc
    function automatic logic [63:0] ent(logic [7:0] hi, logic [19:0] pn,
        logic [9:0] vi, logic [1:0] ty, logic pf, logic v);
        return {6'h0, vi, 8'h0, hi, pn, 5'h0, pf, 3'h0, ty, v};
    endfunction : ent
    // Load the entry pair, then commit it
    task automatic inst(logic [7:0] i, logic [11:0] t, logic [63:0] e,
        logic af);
        wr(8'h00, e[63:32]);
        wr(8'h04, e[31:0]);
        wr(8'h10, {12'h0, t, i});
        wr(8'h0c, {30'h0, af, 1'b1});
    endtask : inst
    // Present a head of queue
    task automatic xs(logic [31:0] a, logic cap);
        @(posedge clk);
        inq_addr             <= a;
        inq_prefetch_capable <= cap;
        inq_valid            <= 1'b1;
        saw_stall = 1'b0;
    endtask : xs
    // Await the bus acknowledge, judge the request, release the head at pop
    task automatic xe(logic [35:0] ea, logic [9:0] ev, logic [1:0] et,
        logic ep, logic es);
        for (int i = 0; i < 300 && sys_ack !== 1'b1; i++) begin
            @(posedge clk);
            #1 saw_stall = saw_stall | (miss_stall === 1'b1);
        end
        chk("sys_ack", 36'h1, {35'h0, sys_ack});
        chk("sys_addr", ea, sys_addr);
        chk("vindex", {26'h0, ev}, {26'h0, sys_vindex});
        chk("type", {34'h0, et}, {34'h0, sys_page_type});
        chk("prefetch", {35'h0, ep}, {35'h0, sys_prefetch_ok});
        chk("stall", {35'h0, es}, {35'h0, saw_stall});
        @(posedge clk);
        inq_valid <= 1'b0;
        #1 chk("pop", 36'h1, {35'h0, inq_pop});
    endtask : xe
    task automatic t_regs;
        rdc(8'h08, 32'hff00_0000);
        rdc(8'h0c, 32'h0000_0002);
        wr(8'h40, 32'hffff_ffff);
        rdc(8'h40, 32'h0);
        wr(8'h04, 32'h9abc_def0);
        rdc(8'h04, 32'h9abc_def0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_types;
        logic [31:0] a;
        for (int t = 0; t < 4; t++) begin
            a = 32'h205a_09c8 + 32'(t) * 32'h0100_1010;
            inst(a[31:24], a[23:12], ent(8'hc0 + 8'(t), 20'h3a5b6,
                10'h2d1 + 10'(t), 2'(t), t[0], 1'b1), 1'b1);
            xs(a, t[1]);
            xe({8'hc0 + 8'(t), 20'h3a5b6, a[11:4]}, 10'h2d1 + 10'(t),
                2'(t), t[0] & t[1], 1'b0);
        end
        $display("test types done");
    endtask : t_types
    task automatic t_miss;
        inst(8'h33, 12'h777, ent(8'h11, 20'h2, 10'h0, 2'h3, 1'b1, 1'b0), 1);
        dir_word <= ent(8'h44, 20'h55555, 10'h1e1, 2'h2, 1'b0, 1'b1);
        lat      <= 4'h5;
        xs(32'h3377_7120, 1'b1);
        xe({28'h4455555, 8'h12}, 10'h1e1, 2'h2, 1'b0, 1'b1);
        chk("dir_addr", 36'h0_0019_bbb8, dir_addr);
        dir_word <= ent(8'h66, 20'h0abcd, 10'h3c3, 2'h1, 1'b1, 1'b1);
        lat      <= 4'h0;
        xs(32'h3388_8040, 1'b1);
        xe({28'h660abcd, 8'h04}, 10'h3c3, 2'h1, 1'b1, 1'b1);
        inst(8'h44, 12'h999, ent(8'h1, 20'h2, 10'h3, 2'h0, 1'b0, 1'b1), 0);
        xs(32'h4412_3ab0, 1'b0);
        repeat (30) @(posedge clk);
        #1 chk("held", 36'h2, {34'h0, miss_stall, sys_req});
        saw_stall = (miss_stall === 1'b1);
        inst(8'h44, 12'h123, ent(8'h77, 20'h13579, 10'h246, 2'h0, 1, 1), 1);
        xe({28'h7713579, 8'hab}, 10'h246, 2'h0, 1'b0, 1'b1);
        rdc(8'h18, 32'h0000_0003);
        $display("test miss done");
    endtask : t_miss
    task automatic t_mask;
        wr(8'h08, 32'h0ff0_0000);
        // Shifted mask folds the new low bits in on the high side
        inst(8'hba, 12'hb5c, ent(8'h9e, 20'h8d7c6, 10'h135, 2'h1, 1, 1), 1);
        xs(32'h0ab5_c3f8, 1'b1);
        xe({28'h9e8d7c6, 8'h3f}, 10'h135, 2'h1, 1'b1, 1'b0);
        $display("test mask done");
    endtask : t_mask
    // Counts, verdict and end of run
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        t_types;
        t_miss;
        t_mask;
        print_verdict;
    end
    // Watchdog well past the expected run
    initial begin
        #60us;
        n_fail++;
        print_verdict;
    end
endmodule : iotl_translator_bench
bind iotl_translator iotl_checker u_iotl_checker (.clk, .reset, .inq_valid,
    .inq_addr, .inq_prefetch_capable, .inq_pop, .sys_req, .sys_addr,
    .sys_page_type, .sys_lock_allowed, .sys_safe_dma, .sys_prefetch_ok,
    .sys_ack, .miss_stall);
